// *** shared/sbd_consts.vh ***
// opcode, field and sequence constants for the opcode decoder
// assumes inclusion by bare name from every decoder design file
`ifndef SBD_CONSTS_VH
`define SBD_CONSTS_VH

// ----------------------------------------
// whole opcode bytes
// ----------------------------------------
`define SBD_OP_SEG_LOAD      8'h8e
`define SBD_OP_SEG_STORE     8'h8c
`define SBD_OP_TABLE_LOOKUP  8'hd7
`define SBD_OP_LOAD_LOC      8'h8d
`define SBD_OP_FAR_FIRST     8'hc5
`define SBD_OP_FAR_SECOND    8'hc4
`define SBD_OP_FLAGS_TO_ACC  8'h9f
`define SBD_OP_ACC_TO_FLAGS  8'h9e
`define SBD_OP_ASCII_PROD    8'hd4
`define SBD_OP_ASCII_QUOT    8'hd5
`define SBD_OP_ADJ_BASE      8'h0a
`define SBD_OP_ASCII_SUM     8'h37
`define SBD_OP_ASCII_DIFF    8'h3f
`define SBD_OP_DEC_SUM       8'h27
`define SBD_OP_DEC_DIFF      8'h2f
`define SBD_OP_BYTE_EXT      8'h98
`define SBD_OP_WORD_EXT      8'h99

// ----------------------------------------
// opcode prefixes (upper bits, width noted)
// ----------------------------------------
`define SBD_PFX_ADD_RM       6'h00
`define SBD_PFX_IMM_GRP      6'h20
`define SBD_PFX_ADD_ACC      7'h02
`define SBD_PFX_ADC_RM       6'h04
`define SBD_PFX_ADC_ACC      7'h0a
`define SBD_PFX_SBB_RM       6'h06
`define SBD_PFX_SBB_ACC      7'h0e
`define SBD_PFX_UNARY_GRP    7'h7b
`define SBD_PFX_IMM_PROD     6'h1a

// ----------------------------------------
// addressing byte subfields
// ----------------------------------------
`define SBD_SUB_ADD          3'h0
`define SBD_SUB_ADC          3'h2
`define SBD_SUB_SBB          3'h3
`define SBD_SUB_UMUL         3'h4
`define SBD_SUB_UDIV         3'h6
`define SBD_SUB_SDIV         3'h7
`define SBD_MOD_NODISP       2'h0
`define SBD_MOD_DISP8        2'h1
`define SBD_MOD_DISP16       2'h2
`define SBD_MOD_REG          2'h3

// ----------------------------------------
// operation codes on opKind
// ----------------------------------------
`define SBD_K_NONE           5'h00
`define SBD_K_SEG_LOAD       5'h01
`define SBD_K_SEG_STORE      5'h02
`define SBD_K_ADD            5'h03
`define SBD_K_ADC            5'h04
`define SBD_K_SBB            5'h05
`define SBD_K_LOOKUP         5'h06
`define SBD_K_LOAD_LOC       5'h07
`define SBD_K_FAR_FIRST      5'h08
`define SBD_K_FAR_SECOND     5'h09
`define SBD_K_FLAGS_TO_ACC   5'h0a
`define SBD_K_ACC_TO_FLAGS   5'h0b
`define SBD_K_UMUL           5'h0c
`define SBD_K_SIMM_MUL       5'h0d
`define SBD_K_UDIV           5'h0e
`define SBD_K_SDIV           5'h0f
`define SBD_K_ASCII_PROD     5'h10
`define SBD_K_ASCII_QUOT     5'h11
`define SBD_K_ASCII_SUM      5'h12
`define SBD_K_ASCII_DIFF     5'h13
`define SBD_K_DEC_SUM        5'h14
`define SBD_K_DEC_DIFF       5'h15
`define SBD_K_BYTE_EXT       5'h16
`define SBD_K_WORD_EXT       5'h17
`define SBD_K_INVALID        5'h1f

// ----------------------------------------
// base and index selections for the operand location
// ----------------------------------------
`define SBD_BASE_NONE        2'h0
`define SBD_BASE_B           2'h1
`define SBD_BASE_BP          2'h2
`define SBD_IDX_NONE         2'h0
`define SBD_IDX_SRC          2'h1
`define SBD_IDX_DST          2'h2

`endif

// *** hw/sbd_operand_locator.v ***
// combinational decode of the addressing byte into operand location parts
// assumes the byte is already registered by the caller
`timescale 1ns/1ns
`include "sbd_consts.vh"

module sbd_operand_locator (
    // addressing byte
    input  wire [7:0] modrm,
    // decoded location
    output reg        regOperand,
    output reg  [1:0] dispBytes,
    output reg        dispSignExt,
    output reg  [1:0] baseSel,
    output reg  [1:0] indexSel
);

    always @* begin
        regOperand  = 1'b0;
        dispBytes   = 2'h0;
        dispSignExt = 1'b0;
        baseSel     = `SBD_BASE_NONE;
        indexSel    = `SBD_IDX_NONE;
        case (modrm[7:6])
            `SBD_MOD_REG:    regOperand = 1'b1;                   // RULE20
            `SBD_MOD_DISP8: begin
                dispBytes   = 2'h1;                               // RULE21
                dispSignExt = 1'b1;
            end
            `SBD_MOD_DISP16: dispBytes = 2'h2;                    // RULE21
            default:         dispBytes = 2'h0;                    // RULE21
        endcase
        if (!regOperand) begin
            case (modrm[2:0])                                     // RULE22
                3'h0: begin baseSel = `SBD_BASE_B;  indexSel = `SBD_IDX_SRC; end
                3'h1: begin baseSel = `SBD_BASE_B;  indexSel = `SBD_IDX_DST; end
                3'h2: begin baseSel = `SBD_BASE_BP; indexSel = `SBD_IDX_SRC; end
                3'h3: begin baseSel = `SBD_BASE_BP; indexSel = `SBD_IDX_DST; end
                3'h4: indexSel = `SBD_IDX_SRC;
                3'h5: indexSel = `SBD_IDX_DST;
                3'h6: begin
                    // form 00 with code 110 would be a direct address; kept to one register here
                    baseSel = `SBD_BASE_BP;
                end
                default: baseSel = `SBD_BASE_B;
            endcase
        end
    end

endmodule

// *** hw/sbd_opcode_decoder.v ***
// opcode decoder: takes opcode and addressing bytes one at a time, reports the operation
// assumes the prefetch logic on the same clock offers bytes with byteValid
`timescale 1ns/1ns
`include "sbd_consts.vh"

// How it works
// (RULE1) 8e then addressing byte: move operand into a segment register.
// (RULE2) 8c then addressing byte: move segment register into an operand.
// (RULE3) sum forms: reg/mem 000000dw, immediate group sub 000, accumulator 0000010w.
// (RULE4) carry sum forms: 000100dw, immediate group sub 010, accumulator 0001010w.
// (RULE5) borrow subtract forms: 000110dw, immediate group sub 011, accumulator 0001110w.
// (RULE6) d7 alone is a table lookup into the accumulator low byte.
// (RULE7) 8d with addressing byte loads the operand location into a register.
// (RULE8) c5 is a far pointer load with data segment; invalid if form 11.
// (RULE9) c4 is a far pointer load with extra segment; memory operand only.
// (RULE10) 9f and 9e move between flags and accumulator high byte, single byte.
// (RULE11) unary group with subfield 100 is an unsigned multiply.
// (RULE12) 011010s1 is signed immediate multiply; second immediate byte only if s=0.
// (RULE13) unary group with subfield 110 is an unsigned divide.
// (RULE14) unary group with subfield 111 is a signed divide.
// (RULE15) d4 then 0a is the ascii adjust after multiply.
// (RULE16) d5 then 0a is the ascii adjust before divide.
// (RULE17) 37 and 3f are ascii adjust after addition and subtraction.
// (RULE18) 27 and 2f are packed decimal adjust after addition and subtraction.
// (RULE19) 98 and 99 sign-extend accumulator byte to word and word to double.
// (RULE20) addressing form 11 means the locator names a register.
// (RULE21) forms 00, 01, 10 give no, one sign-extended, or two displacement bytes.
// (RULE22) locator codes 000-011 use base plus index, 100-111 one register.
// (RULE23) width bit 0 selects byte operand and one immediate byte, 1 word.
// (RULE24) direction bit 1 makes the register field the destination.
module sbd_opcode_decoder (
    // clock and reset
    input  wire       mclk,
    input  wire       rst,
    input  wire       clkEn,
    // byte stream from prefetch
    input  wire       byteValid,
    input  wire [7:0] byteData,
    output wire       byteReady,
    // decoded result
    output reg        decValid_ff,
    output reg  [4:0] opKind_ff,
    output reg        widthWord_ff,
    output reg        dirToReg_ff,
    output reg        signExt_ff,
    output reg        hasModrm_ff,
    output reg  [1:0] immBytes_ff,
    output reg  [7:0] modrm_ff,
    output reg        regOperand_ff,
    output reg  [1:0] dispBytes_ff,
    output reg        dispSignExt_ff,
    output reg  [1:0] baseSel_ff,
    output reg  [1:0] indexSel_ff
);

    // ----------------------------------------
    // state machine
    // ----------------------------------------
    localparam [2:0] ST_OPCODE = 3'h1;
    localparam [2:0] ST_SECOND = 3'h2;
    localparam [2:0] ST_DONE   = 3'h4;

    reg  [2:0] state_ff;
    reg  [2:0] nxt_state;
    reg  [7:0] opcode_ff;
    reg  [7:0] nxt_opcode;
    reg  [4:0] nxt_kind;
    reg        nxt_wide;
    reg        nxt_dir;
    reg        nxt_sext;
    reg        nxt_modrm;
    reg  [1:0] nxt_imm;
    reg        nxt_valid;
    reg  [7:0] nxt_modrmByte;

    wire       locReg;
    wire [1:0] locDisp;
    wire       locSext;
    wire [1:0] locBase;
    wire [1:0] locIdx;

    // one byte taken per enabled cycle while not holding a result
    assign byteReady = clkEn && (state_ff != ST_DONE);

    // ----------------------------------------
    // first-byte classification
    // ----------------------------------------
    // returns {kind, needs second byte, width bit valid, dir bit valid, sign bit valid}
    function [8:0] classify;
        input [7:0] op;
        begin
            classify = {`SBD_K_INVALID, 4'h0};
            if (op[7:2] == `SBD_PFX_ADD_RM)
                classify = {`SBD_K_ADD, 4'b1110};                         // RULE3
            else if (op[7:1] == `SBD_PFX_ADD_ACC)
                classify = {`SBD_K_ADD, 4'b0100};                         // RULE3
            else if (op[7:2] == `SBD_PFX_ADC_RM)
                classify = {`SBD_K_ADC, 4'b1110};                         // RULE4
            else if (op[7:1] == `SBD_PFX_ADC_ACC)
                classify = {`SBD_K_ADC, 4'b0100};                         // RULE4
            else if (op[7:2] == `SBD_PFX_SBB_RM)
                classify = {`SBD_K_SBB, 4'b1110};                         // RULE5
            else if (op[7:1] == `SBD_PFX_SBB_ACC)
                classify = {`SBD_K_SBB, 4'b0100};                         // RULE5
            else if (op[7:2] == `SBD_PFX_IMM_GRP)
                classify = {`SBD_K_NONE, 4'b1101};
            else if (op[7:1] == `SBD_PFX_UNARY_GRP)
                classify = {`SBD_K_NONE, 4'b1100};
            else if (op[7:2] == `SBD_PFX_IMM_PROD && op[0])
                classify = {`SBD_K_SIMM_MUL, 4'b1001};                    // RULE12
            else begin
                case (op)
                    `SBD_OP_SEG_LOAD:     classify = {`SBD_K_SEG_LOAD, 4'b1000};   // RULE1
                    `SBD_OP_SEG_STORE:    classify = {`SBD_K_SEG_STORE, 4'b1000};  // RULE2
                    `SBD_OP_TABLE_LOOKUP: classify = {`SBD_K_LOOKUP, 4'b0000};     // RULE6
                    `SBD_OP_LOAD_LOC:     classify = {`SBD_K_LOAD_LOC, 4'b1000};   // RULE7
                    `SBD_OP_FAR_FIRST:    classify = {`SBD_K_FAR_FIRST, 4'b1000};  // RULE8
                    `SBD_OP_FAR_SECOND:   classify = {`SBD_K_FAR_SECOND, 4'b1000}; // RULE9
                    `SBD_OP_FLAGS_TO_ACC: classify = {`SBD_K_FLAGS_TO_ACC, 4'b0000}; // RULE10
                    `SBD_OP_ACC_TO_FLAGS: classify = {`SBD_K_ACC_TO_FLAGS, 4'b0000}; // RULE10
                    `SBD_OP_ASCII_PROD:   classify = {`SBD_K_ASCII_PROD, 4'b1000}; // RULE15
                    `SBD_OP_ASCII_QUOT:   classify = {`SBD_K_ASCII_QUOT, 4'b1000}; // RULE16
                    `SBD_OP_ASCII_SUM:    classify = {`SBD_K_ASCII_SUM, 4'b0000};  // RULE17
                    `SBD_OP_ASCII_DIFF:   classify = {`SBD_K_ASCII_DIFF, 4'b0000}; // RULE17
                    `SBD_OP_DEC_SUM:      classify = {`SBD_K_DEC_SUM, 4'b0000};    // RULE18
                    `SBD_OP_DEC_DIFF:     classify = {`SBD_K_DEC_DIFF, 4'b0000};   // RULE18
                    `SBD_OP_BYTE_EXT:     classify = {`SBD_K_BYTE_EXT, 4'b0000};   // RULE19
                    `SBD_OP_WORD_EXT:     classify = {`SBD_K_WORD_EXT, 4'b0000};   // RULE19
                    default:              classify = {`SBD_K_INVALID, 4'h0};
                endcase
            end
        end
    endfunction

    // ----------------------------------------
    // immediate byte count
    // ----------------------------------------
    function [1:0] imm_count;
        input [7:0] op;
        begin
            if (op[7:2] == `SBD_PFX_IMM_GRP)
                imm_count = (op[1:0] == 2'h1) ? 2'h2 : 2'h1;
            else if (op[7:2] == `SBD_PFX_IMM_PROD)
                imm_count = op[1] ? 2'h1 : 2'h2;                          // RULE12
            else if (op[7:1] == `SBD_PFX_ADD_ACC || op[7:1] == `SBD_PFX_ADC_ACC
                     || op[7:1] == `SBD_PFX_SBB_ACC)
                imm_count = op[0] ? 2'h2 : 2'h1;                          // RULE23
            else
                imm_count = 2'h0;
        end
    endfunction

    wire [8:0] firstInfo  = classify(byteData);
    wire [8:0] heldInfo   = classify(opcode_ff);
    wire [2:0] subField   = byteData[5:3];

    sbd_operand_locator uLocator (
        .modrm       (modrm_ff),
        .regOperand  (locReg),
        .dispBytes   (locDisp),
        .dispSignExt (locSext),
        .baseSel     (locBase),
        .indexSel    (locIdx)
    );

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------
    always @* begin
        nxt_state     = state_ff;
        nxt_opcode    = opcode_ff;
        nxt_kind      = opKind_ff;
        nxt_wide      = widthWord_ff;
        nxt_dir       = dirToReg_ff;
        nxt_sext      = signExt_ff;
        nxt_modrm     = hasModrm_ff;
        nxt_imm       = immBytes_ff;
        nxt_valid     = 1'b0;
        nxt_modrmByte = modrm_ff;
        case (state_ff)
            ST_OPCODE: begin
                if (byteValid) begin
                    nxt_opcode = byteData;
                    nxt_kind   = firstInfo[8:4];
                    nxt_wide   = firstInfo[2] & byteData[0];              // RULE23
                    nxt_dir    = firstInfo[1] & byteData[1];              // RULE24
                    nxt_sext   = firstInfo[0] & byteData[1];
                    nxt_imm    = imm_count(byteData);
                    nxt_modrm  = firstInfo[3];
                    nxt_modrmByte = 8'h00;
                    if (firstInfo[3]) begin
                        nxt_state = ST_SECOND;
                    end else begin
                        nxt_valid = 1'b1;
                        nxt_state = ST_DONE;
                    end
                end
            end
            ST_SECOND: begin
                if (byteValid) begin
                    nxt_valid = 1'b1;
                    nxt_state = ST_DONE;
                    nxt_modrmByte = byteData;
                    if (opcode_ff[7:2] == `SBD_PFX_IMM_GRP) begin
                        case (subField)
                            `SBD_SUB_ADD: nxt_kind = `SBD_K_ADD;          // RULE3
                            `SBD_SUB_ADC: nxt_kind = `SBD_K_ADC;          // RULE4
                            `SBD_SUB_SBB: nxt_kind = `SBD_K_SBB;          // RULE5
                            default:      nxt_kind = `SBD_K_INVALID;
                        endcase
                    end else if (opcode_ff[7:1] == `SBD_PFX_UNARY_GRP) begin
                        case (subField)
                            `SBD_SUB_UMUL: nxt_kind = `SBD_K_UMUL;        // RULE11
                            `SBD_SUB_UDIV: nxt_kind = `SBD_K_UDIV;        // RULE13
                            `SBD_SUB_SDIV: nxt_kind = `SBD_K_SDIV;        // RULE14
                            default:       nxt_kind = `SBD_K_INVALID;
                        endcase
                    end else if (heldInfo[8:4] == `SBD_K_ASCII_PROD
                                 || heldInfo[8:4] == `SBD_K_ASCII_QUOT) begin
                        // the adjust pair is only legal with the fixed base byte
                        nxt_modrm = 1'b0;
                        if (byteData != `SBD_OP_ADJ_BASE)
                            nxt_kind = `SBD_K_INVALID;                    // RULE15 RULE16
                    end else if ((heldInfo[8:4] == `SBD_K_FAR_FIRST
                                  || heldInfo[8:4] == `SBD_K_FAR_SECOND)
                                 && byteData[7:6] == `SBD_MOD_REG) begin
                        nxt_kind = `SBD_K_INVALID;                        // RULE8 RULE9
                    end
                end
            end
            ST_DONE: begin
                // result held one enabled cycle, then the next opcode is taken
                nxt_state = ST_OPCODE;
            end
            default: nxt_state = ST_OPCODE;
        endcase
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_ff       <= ST_OPCODE;
            opcode_ff      <= 8'h00;
            decValid_ff    <= 1'b0;
            opKind_ff      <= `SBD_K_NONE;
            widthWord_ff   <= 1'b0;
            dirToReg_ff    <= 1'b0;
            signExt_ff     <= 1'b0;
            hasModrm_ff    <= 1'b0;
            immBytes_ff    <= 2'h0;
            modrm_ff       <= 8'h00;
        end else if (clkEn) begin
            state_ff       <= nxt_state;
            opcode_ff      <= nxt_opcode;
            decValid_ff    <= nxt_valid;
            opKind_ff      <= nxt_kind;
            widthWord_ff   <= nxt_wide;
            dirToReg_ff    <= nxt_dir;
            signExt_ff     <= nxt_sext;
            hasModrm_ff    <= nxt_modrm;
            immBytes_ff    <= nxt_imm;
            modrm_ff       <= nxt_modrmByte;
        end
    end

    // location fields follow the captured addressing byte; cleared when none was taken
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            regOperand_ff  <= 1'b0;
            dispBytes_ff   <= 2'h0;
            dispSignExt_ff <= 1'b0;
            baseSel_ff     <= `SBD_BASE_NONE;
            indexSel_ff    <= `SBD_IDX_NONE;
        end else if (clkEn) begin
            regOperand_ff  <= hasModrm_ff & locReg;                      // RULE20
            dispBytes_ff   <= hasModrm_ff ? locDisp : 2'h0;              // RULE21
            dispSignExt_ff <= hasModrm_ff & locSext;
            baseSel_ff     <= hasModrm_ff ? locBase : `SBD_BASE_NONE;    // RULE22
            indexSel_ff    <= hasModrm_ff ? locIdx : `SBD_IDX_NONE;
        end
    end

endmodule

// *** testbench/sbd_decoder_props.sv ***
// concurrent checks on the opcode decoder ports
// assumes a bind to sbd_opcode_decoder; one clock, async reset
`timescale 1ns/1ns
`include "sbd_consts.vh"

module sbd_decoder_props (
    // clock and reset
    input wire       mclk,
    input wire       rst,
    input wire       clkEn,
    // byte stream
    input wire       byteValid,
    input wire [7:0] byteData,
    input wire       byteReady,
    // result
    input wire       decValid_ff,
    input wire [4:0] opKind_ff,
    input wire       widthWord_ff,
    input wire       hasModrm_ff,
    input wire [1:0] immBytes_ff,
    input wire [7:0] modrm_ff,
    input wire       regOperand_ff,
    input wire [1:0] dispBytes_ff,
    input wire       dispSignExt_ff
);
    // ------------
    // opcode tracking
    // ------------
    wire       take = byteValid && byteReady;
    reg        expOp_ff;
    wire       opTake = take && expOp_ff;
    wire [1:0] form = modrm_ff[7:6];

    // without this an addressing byte equal to an opcode would trip the checks
    always @(posedge mclk or posedge rst) begin
        if (rst)
            expOp_ff <= 1'b1;
        else if (clkEn && decValid_ff)
            expOp_ff <= 1'b1;
        else if (take)
            expOp_ff <= 1'b0;
    end

    default clocking dc @(posedge mclk); endclocking
    default disable iff (rst);

    busy_refuse_a: assert property (decValid_ff |-> !byteReady)
        else $error("taken while busy");
    freeze_hold_a: assert property (!clkEn |-> !byteReady ##1
        $stable(decValid_ff) && $stable(opKind_ff)) else $error("state moved while frozen");
    pulse_once_a: assert property (decValid_ff && clkEn |=> !decValid_ff)
        else $error("result pulse too long");
    lookup_single_a: assert property (opTake && byteData == 8'hd7 |=>
        decValid_ff && opKind_ff == `SBD_K_LOOKUP && !hasModrm_ff && immBytes_ff == 2'h0)
        else $error("lookup misdecoded");
    seg_load_a: assert property (opTake && byteData == 8'h8e ##1 take |=>
        decValid_ff && opKind_ff == `SBD_K_SEG_LOAD && modrm_ff == $past(byteData))
        else $error("segment load misdecoded");
    far_reg_a: assert property (opTake && byteData == 8'hc5 ##1 take &&
        byteData[7:6] == 2'h3 |=> opKind_ff == `SBD_K_INVALID)
        else $error("far load reg form taken");
    signed_div_a: assert property (opTake && byteData[7:1] == 7'h7b ##1 take &&
        byteData[5:3] == 3'h7 |=> opKind_ff == `SBD_K_SDIV && widthWord_ff == $past(byteData[0], 2))
        else $error("signed divide misdecoded");
    imm_prod_a: assert property (opTake && byteData[7:2] == 6'h1a && byteData[0] ##1 take |=>
        opKind_ff == `SBD_K_SIMM_MUL && immBytes_ff == ($past(byteData[1], 2) ? 2'h1 : 2'h2))
        else $error("imm product count wrong");
    disp_count_a: assert property (decValid_ff && clkEn && hasModrm_ff && form != 2'h3
        |=> dispBytes_ff == form && dispSignExt_ff == (form == 2'h1))
        else $error("disp count wrong");
    reg_form_a: assert property (decValid_ff && clkEn && hasModrm_ff && form == 2'h3 |=>
        regOperand_ff) else $error("register form not flagged");

    cover property (opTake && byteData == 8'hd4);
    cover property (decValid_ff && hasModrm_ff);
    cover property (!clkEn && byteValid);
endmodule

bind sbd_opcode_decoder sbd_decoder_props u_props (.*);

// *** testbench/sbd_prefetch_model.sv ***
// prefetch stand-in: hands queued bytes to the decoder one at a time
// assumes the bench fills q and sets stall; drives on the falling edge
`timescale 1ns/1ns

module sbd_prefetch_model (
    // clock
    input  wire       mclk,
    // byte stream
    input  wire       byteReady,
    output reg        byteValid = 1'b0,
    output reg  [7:0] byteData = 8'h5a
);
    logic [7:0] q[$];
    int         stall = 0;
    int         waitCnt = 0;
    reg         took_ff = 1'b0;

    always @(posedge mclk) took_ff <= byteValid && byteReady;

    // released data toggles every cycle so a stale byte can never look valid
    always @(negedge mclk) begin
        if (took_ff)
            waitCnt = stall;
        if ((took_ff || !byteValid) && waitCnt == 0 && q.size() > 0) begin
            byteValid = 1'b1;
            byteData = q.pop_front();
        end else if (took_ff || !byteValid) begin
            byteValid = 1'b0;
            byteData = ~byteData;
            if (waitCnt > 0)
                waitCnt--;
        end
    end
endmodule

// *** testbench/test_sixteen_bit_opcode_decoder.sv ***
// self-checking bench for the opcode decoder
// assumes the prefetch model beside it and the bound checker
`timescale 1ns/1ns
`include "sbd_consts.vh"
`define CHK(a, e) begin \
    checks_done++; \
    if ((a) !== (e)) begin \
        err_total++; \
        $display("CHECK FAILED t=%0t got %h want %h", $time, (a), (e)); \
    end \
end

module test_sixteen_bit_opcode_decoder;
    reg        mclk = 1'b0;
    reg        rst = 1'b1;
    reg        clkEn = 1'b1;
    wire       byteValid, byteReady, decValid_ff, widthWord_ff, dirToReg_ff, signExt_ff;
    wire       hasModrm_ff, regOperand_ff, dispSignExt_ff;
    wire [7:0] byteData, modrm_ff;
    wire [4:0] opKind_ff;
    wire [1:0] immBytes_ff, dispBytes_ff, baseSel_ff, indexSel_ff;
    int        err_total = 0;
    int        checks_done = 0;

    always #5 mclk = ~mclk;

    sbd_opcode_decoder DUT (.*);
    sbd_prefetch_model PF (.mclk, .byteReady, .byteValid, .byteData);

    // ------------
    // shared steps
    // ------------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic run(input logic [7:0] b0, b1, input int n, input logic [4:0] k,
                       input logic w, d, h, input logic [1:0] imm);
        if (n > 0)
            PF.q.push_back(b0);
        if (n > 1)
            PF.q.push_back(b1);
        for (int i = 0; i < 40 && decValid_ff !== 1'b1; i++)
            @(negedge mclk);
        if (decValid_ff !== 1'b1) begin
            err_total++;
            $display("CHECK FAILED t=%0t no result", $time);
            wrap_up();
        end
        `CHK(opKind_ff, k)
        if (k !== `SBD_K_INVALID) begin
            `CHK(widthWord_ff, w)
            `CHK(dirToReg_ff, d)
            `CHK(hasModrm_ff, h)
            `CHK(immBytes_ff, imm)
            if (h)
                `CHK(modrm_ff, b1)
        end
        @(negedge mclk);
    endtask

    // location fields settle one cycle after the result
    task automatic loc(input logic r, input logic [1:0] disp, base, idx);
        `CHK(regOperand_ff, r)
        `CHK(dispBytes_ff, disp)
        if (!r) begin
            `CHK(baseSel_ff, base)
            `CHK(indexSel_ff, idx)
        end
    endtask

    // ------------
    // scenarios
    // ------------
    task automatic t_single();
        logic [7:0] op[9] = '{8'hd7, 8'h9f, 8'h9e, 8'h37, 8'h3f, 8'h27, 8'h2f, 8'h98, 8'h99};
        logic [4:0] k[9] = '{`SBD_K_LOOKUP, `SBD_K_FLAGS_TO_ACC, `SBD_K_ACC_TO_FLAGS,
            `SBD_K_ASCII_SUM, `SBD_K_ASCII_DIFF, `SBD_K_DEC_SUM, `SBD_K_DEC_DIFF,
            `SBD_K_BYTE_EXT, `SBD_K_WORD_EXT};
        for (int i = 0; i < 9; i++)
            run(op[i], 8'h00, 1, k[i], 0, 0, 0, 2'h0);
        $display("test single finished");
    endtask

    task automatic t_arith();
        run(8'h03, 8'hc1, 2, `SBD_K_ADD, 1, 1, 1, 2'h0);
        loc(1, 2'h0, 2'h0, 2'h0);
        run(8'h10, 8'h47, 2, `SBD_K_ADC, 0, 0, 1, 2'h0);
        loc(0, 2'h1, 2'h1, 2'h0);
        run(8'h1a, 8'h80, 2, `SBD_K_SBB, 0, 1, 1, 2'h0);
        loc(0, 2'h2, 2'h1, 2'h1);
        run(8'h81, 8'hc0, 2, `SBD_K_ADD, 1, 0, 1, 2'h2);
        `CHK(signExt_ff, 1'b0)
        run(8'h83, 8'hd1, 2, `SBD_K_ADC, 1, 0, 1, 2'h1);
        `CHK(signExt_ff, 1'b1)
        run(8'h08, 8'h00, 1, `SBD_K_INVALID, 0, 0, 0, 2'h0);
        run(8'h80, 8'hd8, 2, `SBD_K_SBB, 0, 0, 1, 2'h1);
        run(8'h05, 8'h00, 1, `SBD_K_ADD, 1, 0, 0, 2'h2);
        run(8'h14, 8'h00, 1, `SBD_K_ADC, 0, 0, 0, 2'h1);
        run(8'h1d, 8'h00, 1, `SBD_K_SBB, 1, 0, 0, 2'h2);
        $display("test arith finished");
    endtask

    task automatic t_muldiv();
        run(8'hf6, 8'he0, 2, `SBD_K_UMUL, 0, 0, 1, 2'h0);
        run(8'hf6, 8'hd8, 2, `SBD_K_INVALID, 0, 0, 1, 2'h0);
        run(8'hf7, 8'hf1, 2, `SBD_K_UDIV, 1, 0, 1, 2'h0);
        run(8'hf7, 8'h3f, 2, `SBD_K_SDIV, 1, 0, 1, 2'h0);
        loc(0, 2'h0, 2'h1, 2'h0);
        run(8'h69, 8'hc3, 2, `SBD_K_SIMM_MUL, 0, 0, 1, 2'h2);
        run(8'h6b, 8'h47, 2, `SBD_K_SIMM_MUL, 0, 0, 1, 2'h1);
        $display("test muldiv finished");
    endtask

    task automatic t_transfer();
        run(8'h8e, 8'hd8, 2, `SBD_K_SEG_LOAD, 0, 0, 1, 2'h0);
        loc(1, 2'h0, 2'h0, 2'h0);
        run(8'h8c, 8'h46, 2, `SBD_K_SEG_STORE, 0, 0, 1, 2'h0);
        loc(0, 2'h1, 2'h2, 2'h0);
        run(8'h8d, 8'h84, 2, `SBD_K_LOAD_LOC, 0, 0, 1, 2'h0);
        loc(0, 2'h2, 2'h0, 2'h1);
        run(8'hc5, 8'h17, 2, `SBD_K_FAR_FIRST, 0, 0, 1, 2'h0);
        run(8'hc4, 8'h03, 2, `SBD_K_FAR_SECOND, 0, 0, 1, 2'h0);
        loc(0, 2'h0, 2'h2, 2'h2);
        run(8'hc5, 8'hc0, 2, `SBD_K_INVALID, 0, 0, 1, 2'h0);
        run(8'hc4, 8'hd8, 2, `SBD_K_INVALID, 0, 0, 1, 2'h0);
        $display("test transfer finished");
    endtask

    task automatic t_adjust();
        PF.stall = 2;
        run(8'hd4, 8'h0a, 2, `SBD_K_ASCII_PROD, 0, 0, 0, 2'h0);
        run(8'hd5, 8'h0a, 2, `SBD_K_ASCII_QUOT, 0, 0, 0, 2'h0);
        run(8'hd4, 8'h0b, 2, `SBD_K_INVALID, 0, 0, 0, 2'h0);
        PF.stall = 0;
        $display("test adjust finished");
    endtask

    task automatic t_freeze();
        clkEn = 1'b0;
        PF.q.push_back(8'h98);
        repeat (4) begin
            @(negedge mclk);
            `CHK(byteReady, 1'b0)
            `CHK(decValid_ff, 1'b0)
        end
        clkEn = 1'b1;
        run(8'h98, 8'h00, 0, `SBD_K_BYTE_EXT, 0, 0, 0, 2'h0);
        $display("test freeze finished");
    endtask

    initial begin
        repeat (16) @(negedge mclk);
        `CHK(byteReady, 1'b1)
        `CHK(decValid_ff, 1'b0)
        rst = 1'b0;
        t_single();
        t_arith();
        t_muldiv();
        t_transfer();
        t_adjust();
        t_freeze();
        wrap_up();
    end
endmodule
